// ### hpx_defines.vh
// Purpose: constants for the host port halfword access block
// Assumes: included by hpx_host_port.v, the checker and the test bench, not by hpx_wbuf.v
// Notes:   host access codes, control bits, apb map, queue codes
`ifndef HPX_DEFINES_VH
`define HPX_DEFINES_VH

// host access select codes
`define HPX_SEL_CTRL     2'b00
`define HPX_SEL_ADDR     2'b01
`define HPX_SEL_DATA_INC 2'b10
`define HPX_SEL_DATA_FIX 2'b11

// control register bits
`define HPX_CTL_ORDER_BIT 0
`define HPX_CTL_BOOT_BIT  1
`define HPX_CTL_RST       2'b00

// transfer queue codes
`define HPX_QUEUE_HIGH 2'b01
`define HPX_QUEUE_MED  2'b10

// apb register byte offsets
`define HPX_REG_CFG    12'h000
`define HPX_REG_STATUS 12'h004
`define HPX_REG_ADDR   12'h008
`define HPX_REG_DATA   12'h00c

// configuration bits and reset value
`define HPX_CFG_WIDE_BIT 0
`define HPX_CFG_RST      1'b0

// address step of one word
`define HPX_ADDR_STEP 32'h0000_0004

`endif

// ### hpx_wbuf.v
// Purpose: write buffer storage for wide autoincrement writes
// Assumes: one write and one read port, same clock
// Notes:   read data come out of a register one cycle after i_rd_en
`default_nettype none

module hpx_wbuf #(
  parameter W  = 36,
  parameter AW = 3
) (
  // clock and reset
  input  wire          i_clk,
  input  wire          i_rst_n,
  // write port
  input  wire          i_wr_en,
  input  wire [AW-1:0] i_wr_addr,
  input  wire [W-1:0]  i_wr_data,
  // read port
  input  wire          i_rd_en,
  input  wire [AW-1:0] i_rd_addr,
  output reg  [W-1:0]  o_rd_data
);

  reg [W-1:0] mem_r [0:(1<<AW)-1];

  always @(posedge i_clk) begin
    if (i_wr_en) begin
      mem_r[i_wr_addr] <= i_wr_data;
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rd_data <= {W{1'b0}};
    end else if (i_rd_en) begin
      o_rd_data <= mem_r[i_rd_addr];
    end
  end

endmodule

`default_nettype wire

// ### hpx_host_port.v
// Purpose: host port with halfword access, prefetch, write buffer, apb status
// Assumes: host pins are asynchronous; memory side is on i_clk
// Notes:   host waits for ready before its next strobe
`include "hpx_defines.vh"
`default_nettype none

module hpx_host_port #(
  parameter WBUF_AW = 3
) (
  // clock and reset
  input  wire        i_clk,
  input  wire        i_rst_n,
  // apb slave
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [11:0] i_paddr,
  input  wire [31:0] i_pwdata,
  output reg  [31:0] o_prdata,
  output wire        o_pready,
  output wire        o_pslverr,
  // host pins
  input  wire        i_host_chip_select_n,
  input  wire        i_host_strobe_n,
  input  wire        i_host_read_write,
  input  wire [1:0]  i_host_access_select,
  input  wire        i_halfword_select,
  input  wire [3:0]  i_host_byte_enables_n,
  input  wire [31:0] i_host_data,
  output reg  [31:0] o_host_data,
  output reg         o_host_data_oe,
  output reg         o_host_ready_n,
  // chip reset and boot
  input  wire        i_chip_rst_n,
  input  wire        i_boot_mode,
  output reg         o_core_hold,
  // memory request port
  output reg         o_mem_req,
  output reg         o_mem_write,
  output reg  [31:0] o_mem_addr,
  output reg  [31:0] o_mem_wdata,
  output reg  [3:0]  o_mem_be,
  output wire [1:0]  o_mem_queue,
  input  wire        i_mem_ack,
  input  wire [31:0] i_mem_rdata
);

  localparam SYN_W = 44;
  localparam [WBUF_AW:0] HALF_CNT = {2'b01, {(WBUF_AW-1){1'b0}}};

  localparam [2:0] S_IDLE  = 3'd0;
  localparam [2:0] S_RD    = 3'd1;
  localparam [2:0] S_WR    = 3'd2;
  localparam [2:0] S_PF    = 3'd3;
  localparam [2:0] S_FL_RD = 3'd4;
  localparam [2:0] S_FL_LD = 3'd5;
  localparam [2:0] S_FL_WR = 3'd6;

  // pin synchronisers
  reg  [SYN_W-1:0] syn1_r;
  reg  [SYN_W-1:0] syn2_r;
  wire [SYN_W-1:0] pins;
  assign pins = {i_host_chip_select_n, i_host_strobe_n, i_host_read_write,
                 i_host_access_select, i_halfword_select, i_host_byte_enables_n,
                 i_host_data, i_chip_rst_n, i_boot_mode};

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      syn1_r <= {{2{1'b1}}, {(SYN_W-2){1'b0}}};
      syn2_r <= {{2{1'b1}}, {(SYN_W-2){1'b0}}};
    end else begin
      syn1_r <= pins;
      syn2_r <= syn1_r;
    end
  end

  wire        cs_n_s  = syn2_r[43];
  wire        strb_s  = syn2_r[42];
  wire        rd_s    = syn2_r[41];
  wire [1:0]  sel_s   = syn2_r[40:39];
  wire        hsel_s  = syn2_r[38];
  wire [3:0]  be_n_s  = syn2_r[37:34];
  wire [31:0] hd_s    = syn2_r[33:2];
  wire        chip_run = syn2_r[1];
  wire        boot_s  = syn2_r[0];

  // state
  reg [2:0]         state_r;
  reg               strb_d_r;
  reg               cfg_wide_r;
  reg [1:0]         ctl_r;
  reg [31:0]        addr_r;
  reg [31:0]        data_r;
  reg [3:0]         be_n_r;
  reg               inc_after_r;
  reg               pf_pend_r;
  reg               pf_valid_r;
  reg [31:0]        pf_addr_r;
  reg [31:0]        pf_data_r;
  reg               boot_r;
  reg [WBUF_AW:0]   cnt_r;
  reg [WBUF_AW:0]   idx_r;
  reg [31:0]        base_r;

  wire        halfword_order_bit   = ctl_r[`HPX_CTL_ORDER_BIT];
  wire        upper  = ~(hsel_s ^ halfword_order_bit);
  wire        is_data = sel_s[1];
  wire        is_inc  = (sel_s == `HPX_SEL_DATA_INC);
  wire        fall   = strb_d_r & ~strb_s;
  // access taken only outside chip reset and when idle
  wire        acc    = fall & ~cs_n_s & chip_run & (state_r == S_IDLE);
  wire [15:0] half_in = hd_s[15:0];
  wire [31:0] ctl_word = {14'h0000, ctl_r, 14'h0000, ctl_r};

  // merged write word for a second halfword
  wire [31:0] data_mrg = upper ? {half_in, data_r[15:0]} : {data_r[31:16], half_in};
  wire [3:0]  be_mrg   = upper ? {be_n_s[1:0], be_n_r[1:0]} : {be_n_r[3:2], be_n_s[1:0]};

  // write buffer
  wire        wb_wr_en = acc & ~rd_s & is_inc & cfg_wide_r;
  wire        wb_rd_en = (state_r == S_FL_RD);
  wire [35:0] wb_rd_data;

  hpx_wbuf #(
    .W  (36),
    .AW (WBUF_AW)
  ) u_wbuf (
    .i_clk     (i_clk),
    .i_rst_n   (i_rst_n),
    .i_wr_en   (wb_wr_en),
    .i_wr_addr (cnt_r[WBUF_AW-1:0]),
    .i_wr_data ({be_n_s, hd_s}),
    .i_rd_en   (wb_rd_en),
    .i_rd_addr (idx_r[WBUF_AW-1:0]),
    .o_rd_data (wb_rd_data)
  );

  // queue choice follows the variant
  assign o_mem_queue = cfg_wide_r ? `HPX_QUEUE_MED : `HPX_QUEUE_HIGH;

  // main sequencer
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r     <= S_IDLE;
      strb_d_r    <= 1'b1;
      ctl_r       <= `HPX_CTL_RST;
      addr_r      <= 32'h0000_0000;
      data_r      <= 32'h0000_0000;
      be_n_r      <= 4'hf;
      inc_after_r <= 1'b0;
      pf_pend_r   <= 1'b0;
      pf_valid_r  <= 1'b0;
      pf_addr_r   <= 32'h0000_0000;
      pf_data_r   <= 32'h0000_0000;
      boot_r      <= 1'b0;
      o_core_hold <= 1'b1;
      cnt_r       <= {(WBUF_AW+1){1'b0}};
      idx_r       <= {(WBUF_AW+1){1'b0}};
      base_r      <= 32'h0000_0000;
      o_mem_req   <= 1'b0;
      o_mem_write <= 1'b0;
      o_mem_addr  <= 32'h0000_0000;
      o_mem_wdata <= 32'h0000_0000;
      o_mem_be    <= 4'h0;
    end else begin
      strb_d_r <= strb_s;
      if (!chip_run) begin
        // chip reset: drop all work, catch boot strap, hold core
        state_r     <= S_IDLE;
        pf_pend_r   <= 1'b0;
        pf_valid_r  <= 1'b0;
        cnt_r       <= {(WBUF_AW+1){1'b0}};
        o_mem_req   <= 1'b0;
        boot_r      <= boot_s;
        o_core_hold <= 1'b1;
      end else begin
        if (!boot_r) begin
          o_core_hold <= 1'b0;
        end
        case (state_r)
          S_IDLE: begin
            if (acc) begin
              case (sel_s)
                `HPX_SEL_CTRL: begin
                  if (!rd_s) begin
                    // whole register whatever the halfword select
                    ctl_r <= half_in[1:0];
                    if (half_in[`HPX_CTL_BOOT_BIT]) begin
                      o_core_hold <= 1'b0;
                    end
                  end
                end
                `HPX_SEL_ADDR: begin
                  if (!rd_s) begin
                    if (cfg_wide_r) begin
                      addr_r <= hd_s;
                    end else if (upper) begin
                      addr_r[31:16] <= half_in;
                    end else begin
                      addr_r[15:0] <= half_in;
                    end
                    pf_pend_r  <= 1'b0;
                    pf_valid_r <= 1'b0;
                  end
                end
                default: begin
                  if (rd_s && (cfg_wide_r || !hsel_s)) begin
                    // first halfword launches the read unless the prefetch holds this address
                    pf_pend_r   <= 1'b0;
                    inc_after_r <= cfg_wide_r & is_inc;
                    if (pf_valid_r && pf_addr_r == addr_r) begin
                      data_r     <= pf_data_r;
                      pf_valid_r <= 1'b0;
                      if (cfg_wide_r && is_inc) begin
                        addr_r    <= addr_r + `HPX_ADDR_STEP;
                        pf_pend_r <= 1'b1;
                      end
                    end else begin
                      pf_valid_r  <= 1'b0;
                      o_mem_req   <= 1'b1;
                      o_mem_write <= 1'b0;
                      o_mem_addr  <= addr_r;
                      state_r     <= S_RD;
                    end
                  end else if (rd_s) begin
                    // second halfword read: only now may prefetch begin
                    if (is_inc) begin
                      addr_r    <= addr_r + `HPX_ADDR_STEP;
                      pf_pend_r <= 1'b1;
                    end
                  end else if (cfg_wide_r && is_inc) begin
                    // copied into the buffer at once, no busy unless it brings the count to half the buffer
                    if (cnt_r == {(WBUF_AW+1){1'b0}}) begin
                      base_r <= addr_r;
                    end
                    addr_r <= addr_r + `HPX_ADDR_STEP;
                    cnt_r  <= cnt_r + 1'b1;
                    if (cnt_r + 1'b1 == HALF_CNT) begin
                      idx_r   <= {(WBUF_AW+1){1'b0}};
                      state_r <= S_FL_RD;
                    end
                  end else if (cfg_wide_r) begin
                    o_mem_req   <= 1'b1;
                    o_mem_write <= 1'b1;
                    o_mem_addr  <= addr_r;
                    o_mem_wdata <= hd_s;
                    o_mem_be    <= ~be_n_s;
                    inc_after_r <= 1'b0;
                    state_r     <= S_WR;
                  end else if (!hsel_s) begin
                    // first halfword only stored
                    if (upper) begin
                      data_r[31:16] <= half_in;
                      be_n_r[3:2]   <= be_n_s[1:0];
                    end else begin
                      data_r[15:0]  <= half_in;
                      be_n_r[1:0]   <= be_n_s[1:0];
                    end
                  end else begin
                    // second halfword launches the write
                    data_r      <= data_mrg;
                    be_n_r      <= be_mrg;
                    o_mem_req   <= 1'b1;
                    o_mem_write <= 1'b1;
                    o_mem_addr  <= addr_r;
                    o_mem_wdata <= data_mrg;
                    o_mem_be    <= ~be_mrg;
                    inc_after_r <= is_inc;
                    state_r     <= S_WR;
                  end
                end
              endcase
            end else if (cs_n_s && cnt_r != {(WBUF_AW+1){1'b0}}) begin
              // write cycle ended: service the buffer
              idx_r   <= {(WBUF_AW+1){1'b0}};
              state_r <= S_FL_RD;
            end else if (pf_pend_r) begin
              pf_pend_r   <= 1'b0;
              pf_addr_r   <= addr_r;
              o_mem_req   <= 1'b1;
              o_mem_write <= 1'b0;
              o_mem_addr  <= addr_r;
              state_r     <= S_PF;
            end
          end
          S_RD: begin
            if (i_mem_ack) begin
              o_mem_req <= 1'b0;
              data_r    <= i_mem_rdata;
              state_r   <= S_IDLE;
              if (inc_after_r) begin
                addr_r    <= addr_r + `HPX_ADDR_STEP;
                pf_pend_r <= 1'b1;
              end
            end
          end
          S_WR: begin
            if (i_mem_ack) begin
              o_mem_req <= 1'b0;
              state_r   <= S_IDLE;
              if (inc_after_r) begin
                addr_r <= addr_r + `HPX_ADDR_STEP;
              end
            end
          end
          S_PF: begin
            if (i_mem_ack) begin
              o_mem_req  <= 1'b0;
              pf_data_r  <= i_mem_rdata;
              pf_valid_r <= 1'b1;
              state_r    <= S_IDLE;
            end
          end
          S_FL_RD: begin
            state_r <= S_FL_LD;
          end
          S_FL_LD: begin
            o_mem_req   <= 1'b1;
            o_mem_write <= 1'b1;
            o_mem_addr  <= base_r + {{(30-WBUF_AW-1){1'b0}}, idx_r, 2'b00};
            o_mem_wdata <= wb_rd_data[31:0];
            o_mem_be    <= ~wb_rd_data[35:32];
            state_r     <= S_FL_WR;
          end
          S_FL_WR: begin
            if (i_mem_ack) begin
              o_mem_req <= 1'b0;
              if (idx_r + 1'b1 == cnt_r) begin
                cnt_r   <= {(WBUF_AW+1){1'b0}};
                state_r <= S_IDLE;
              end else begin
                idx_r   <= idx_r + 1'b1;
                state_r <= S_FL_RD;
              end
            end
          end
          default: begin
            state_r <= S_IDLE;
          end
        endcase
      end
    end
  end

  // a buffered wide write short of half the buffer or a stored first half keeps ready active
  wire is_inc_wr_ok = ~rd_s & ((cfg_wide_r & is_inc & (cnt_r + 1'b1 != HALF_CNT)) | (~cfg_wide_r & ~hsel_s))
                      | rd_s & ~cfg_wide_r & hsel_s | rd_s & pf_valid_r & (pf_addr_r == addr_r);

  // host read data, data enable and ready
  wire [31:0] rd_word = (sel_s == `HPX_SEL_CTRL) ? ctl_word :
                        (sel_s == `HPX_SEL_ADDR) ? addr_r : data_r;

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_host_data    <= 32'h0000_0000;
      o_host_data_oe <= 1'b0;
      o_host_ready_n <= 1'b1;
    end else begin
      if (cfg_wide_r) begin
        o_host_data <= rd_word;
      end else if (upper) begin
        o_host_data <= {16'h0000, rd_word[31:16]};
      end else begin
        o_host_data <= {16'h0000, rd_word[15:0]};
      end
      o_host_data_oe <= ~cs_n_s & ~strb_s & rd_s & chip_run;
      if (!chip_run) begin
        o_host_ready_n <= ~cs_n_s;
      end else begin
        o_host_ready_n <= (state_r != S_IDLE) | acc & is_data & ~is_inc_wr_ok;
      end
    end
  end

  // apb slave
  wire apb_setup = i_psel & ~i_penable;
  wire apb_wr    = i_psel & i_penable & i_pwrite;
  wire mapped    = (i_paddr == `HPX_REG_CFG) | (i_paddr == `HPX_REG_STATUS) |
                   (i_paddr == `HPX_REG_ADDR) | (i_paddr == `HPX_REG_DATA);

  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~mapped;

  wire [31:0] status_word = {16'h0000, {(7-WBUF_AW){1'b0}}, cnt_r,
                             boot_r, o_core_hold, ~chip_run, pf_valid_r, pf_pend_r, state_r};

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_wide_r <= `HPX_CFG_RST;
      o_prdata   <= 32'h0000_0000;
    end else begin
      if (apb_wr && i_paddr == `HPX_REG_CFG) begin
        cfg_wide_r <= i_pwdata[`HPX_CFG_WIDE_BIT];
      end
      if (apb_setup) begin
        case (i_paddr)
          `HPX_REG_CFG:    o_prdata <= {31'h0000_0000, cfg_wide_r};
          `HPX_REG_STATUS: o_prdata <= status_word;
          `HPX_REG_ADDR:   o_prdata <= addr_r;
          `HPX_REG_DATA:   o_prdata <= data_r;
          default:         o_prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ### hpx_host_port_chk.sv
// Purpose: port assertions for hpx_host_port
// Assumes: bound to hpx_host_port
// Notes:   sees top ports only
`include "hpx_defines.vh"
`default_nettype none
module hpx_host_port_chk (
  // clock and reset
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  // apb
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic        o_pslverr,
  // host, chip and memory
  input wire logic        i_host_chip_select_n,
  input wire logic        o_host_ready_n,
  input wire logic        i_chip_rst_n,
  input wire logic        i_boot_mode,
  input wire logic        o_core_hold,
  input wire logic        o_mem_req,
  input wire logic [31:0] o_mem_addr,
  input wire logic [31:0] o_mem_wdata,
  input wire logic [1:0]  o_mem_queue,
  input wire logic        i_mem_ack
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic wide_r;
  // mirror of the wide mode bit
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      wide_r <= 1'b0;
    else if (i_psel && i_penable && i_pwrite && i_paddr == `HPX_REG_CFG)
      wide_r <= i_pwdata[`HPX_CFG_WIDE_BIT];
  end
  a_ready_selected:
    assert property ((!i_chip_rst_n && !i_host_chip_select_n) [*5] |-> o_host_ready_n)
    else $error("ready active while selected in chip reset");
  a_ready_free:
    assert property ((!i_chip_rst_n && i_host_chip_select_n) [*5] |-> !o_host_ready_n)
    else $error("ready inactive while deselected in chip reset");
  a_reset_no_service:
    assert property (!i_chip_rst_n [*4] |-> !o_mem_req)
    else $error("memory request during chip reset");
  a_core_held:
    assert property (!i_chip_rst_n [*4] |-> o_core_hold)
    else $error("core free during chip reset");
  a_boot_hold:
    assert property ($rose(i_chip_rst_n) && i_boot_mode |-> o_core_hold [*8])
    else $error("core released too early in boot mode");
  a_queue_code:
    assert property (o_mem_req |-> o_mem_queue == (wide_r ? `HPX_QUEUE_MED : `HPX_QUEUE_HIGH))
    else $error("wrong transfer queue");
  a_req_held:
    assert property (o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr) && $stable(o_mem_wdata))
    else $error("request changed before ack");
  a_req_drop:
    assert property (o_mem_req && i_mem_ack |=> !o_mem_req)
    else $error("request kept after ack");
  a_slverr_map:
    assert property (i_psel && i_penable |-> o_pslverr == (i_paddr > `HPX_REG_DATA || i_paddr[1:0] != 2'b00))
    else $error("slave error does not match address map");
endmodule
bind hpx_host_port hpx_host_port_chk u_hpx_host_port_chk (.*);
`default_nettype wire

// ### hpx_host_model.sv
// Purpose: host processor model on the host port pins
// Assumes: one access at a time
// Notes:   data pins toggle while the host reads
`default_nettype none
module hpx_host_model (
  // clock and answers
  input  wire logic        i_clk,
  input  wire logic        i_ready_n,
  input  wire logic [31:0] i_data,
  // host pins
  output logic             o_cs_n,
  output logic             o_stb_n,
  output logic             o_rnw,
  output logic [1:0]       o_sel,
  output logic             o_hw,
  output logic [31:0]      o_data
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_cs_n = 1'b1;
    o_stb_n = 1'b1;
    o_rnw = 1'b1;
    o_sel = 2'b00;
    o_hw = 1'b0;
    o_data = 32'h0;
  end
  // pins held until ready; halfword order kept by the caller
  task automatic access(input logic rnw, input logic [1:0] sel, input logic hw,
                        input logic [31:0] wd, output logic [31:0] rd, output logic ok);
    int n;
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    o_rnw <= rnw;
    o_sel <= sel;
    o_hw <= hw;
    o_data <= rnw ? ~o_data : wd;
    @(posedge i_clk);
    o_stb_n <= 1'b0;
    repeat (6) @(posedge i_clk);
    n = 0;
    while (i_ready_n !== 1'b0 && n < 500) begin
      @(posedge i_clk);
      n++;
    end
    rd = i_data;
    ok = n < 500;
    o_stb_n <= 1'b1;
    repeat (5) @(posedge i_clk);
  endtask
  // write strobe during chip reset, no wait
  task automatic poke();
    @(posedge i_clk);
    o_rnw <= 1'b0;
    o_sel <= 2'b11;
    o_stb_n <= 1'b0;
    repeat (6) @(posedge i_clk);
    o_stb_n <= 1'b1;
  endtask
  task automatic select(input logic v);
    @(posedge i_clk);
    o_cs_n <= v;
  endtask
endmodule
`default_nettype wire

// ### hpx_host_port_test.sv
// Purpose: self-checking bench for hpx_host_port
// Assumes: memory answers two cycles after a request
// Notes:   narrow accesses first, then wide writes
`include "hpx_defines.vh"
`default_nettype none
module hpx_host_port_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int AW = 3;
  localparam int HALF = 1 << (AW - 1);
  logic        i_clk, i_rst_n, i_chip_rst_n, i_psel, i_penable, i_pwrite, e;
  logic        o_pready, o_pslverr, o_host_ready_n, o_core_hold, o_mem_req, o_mem_write;
  logic        h_cs_n, h_stb_n, h_rnw, h_hw, o_host_data_oe, req_d;
  logic        i_mem_ack = 1'b0;
  logic [1:0]  h_sel, o_mem_queue, wq[$];
  logic [3:0]  o_mem_be, h_be_n, wb[$];
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, o_host_data, h_data, o_mem_addr, o_mem_wdata, i_mem_rdata, r;
  logic [31:0] wa[$], wd[$], ra[$];
  int          mismatches, checked, oe_cnt, rdy_hi;
  hpx_host_port #(.WBUF_AW(AW)) u_hpx_host_port (
    .*,
    .i_host_chip_select_n (h_cs_n),
    .i_host_strobe_n      (h_stb_n),
    .i_host_read_write    (h_rnw),
    .i_host_access_select (h_sel),
    .i_halfword_select    (h_hw),
    .i_host_byte_enables_n(h_be_n),
    .i_host_data          (h_data),
    .i_boot_mode          (1'b1)
  );
  hpx_host_model u_hpx_host_model (
    .i_clk    (i_clk),
    .i_ready_n(o_host_ready_n),
    .i_data   (o_host_data),
    .o_cs_n   (h_cs_n),
    .o_stb_n  (h_stb_n),
    .o_rnw    (h_rnw),
    .o_sel    (h_sel),
    .o_hw     (h_hw),
    .o_data   (h_data)
  );
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  // memory: ack pulse, log of finished requests
  assign i_mem_rdata = i_mem_ack ? o_mem_addr ^ 32'hc3c3_0000 : ~o_mem_addr;
  always @(posedge i_clk) begin
    i_mem_ack <= o_mem_req && req_d && !i_mem_ack;
    req_d <= o_mem_req;
    if (o_host_data_oe) oe_cnt <= oe_cnt + 1;
    if (o_host_ready_n) rdy_hi <= rdy_hi + 1;
    if (o_mem_req && i_mem_ack && o_mem_write) begin
      wa.push_back(o_mem_addr);
      wd.push_back(o_mem_wdata);
      wb.push_back(o_mem_be);
      wq.push_back(o_mem_queue);
    end
    if (o_mem_req && i_mem_ack && !o_mem_write)
      ra.push_back(o_mem_addr);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 50);
    r = o_prdata;
    e = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    chk(n < 50, 32'h1);
    if (n >= 50) conclude();
  endtask
  task automatic acc(input logic rnw, input logic [1:0] s, input logic hw, input logic [31:0] d);
    logic ok;
    u_hpx_host_model.access(rnw, s, hw, d, r, ok);
    chk(ok, 32'h1);
    if (ok !== 1'b1) conclude();
  endtask
  task automatic wait_wr(input int k);
    int n;
    n = 0;
    while (wa.size() < k && n < 300) begin
      @(posedge i_clk);
      n++;
    end
    chk(wa.size(), k);
    if (n >= 300) conclude();
  endtask
  task automatic t_reset();
    u_hpx_host_model.select(1'b0);
    repeat (8) @(posedge i_clk);
    chk(o_host_ready_n, 1'b1);
    u_hpx_host_model.poke();
    repeat (8) @(posedge i_clk);
    chk(wa.size() + ra.size(), 0);
    u_hpx_host_model.select(1'b1);
    repeat (8) @(posedge i_clk);
    chk(o_host_ready_n, 1'b0);
    i_chip_rst_n <= 1'b1;
    repeat (8) @(posedge i_clk);
    chk(o_core_hold, 1'b1);
  endtask
  task automatic t_regs();
    logic [31:0] h;
    apb(1'b0, 12'h010, 32'h0);
    chk(e, 1'b1);
    acc(1'b0, `HPX_SEL_CTRL, 1'b1, 32'h1);
    chk(oe_cnt, 0);
    acc(1'b1, `HPX_SEL_CTRL, 1'b0, 32'h0);
    h = r;
    chk(oe_cnt != 0, 1'b1);
    acc(1'b1, `HPX_SEL_CTRL, 1'b1, 32'h0);
    chk(h[15:0], 16'h0001);
    chk(r[15:0], h[15:0]);
    acc(1'b0, `HPX_SEL_ADDR, 1'b0, 32'h1234);
    acc(1'b0, `HPX_SEL_ADDR, 1'b1, 32'h4000);
    apb(1'b0, `HPX_REG_ADDR, 32'h0);
    chk(r, 32'h4000_1234);
    acc(1'b0, `HPX_SEL_ADDR, 1'b1, 32'h8000);
    apb(1'b0, `HPX_REG_ADDR, 32'h0);
    chk(r, 32'h8000_1234);
  endtask
  task automatic t_write();
    acc(1'b0, `HPX_SEL_DATA_INC, 1'b0, 32'h5566);
    repeat (10) @(posedge i_clk);
    chk(wa.size(), 0);
    acc(1'b0, `HPX_SEL_DATA_INC, 1'b1, 32'h3300);
    wait_wr(1);
    chk(wa[0], 32'h8000_1234);
    chk(wd[0], 32'h3300_5566);
    chk(wb[0], 4'hf);
    chk(wq[0], `HPX_QUEUE_HIGH);
    h_be_n <= 4'h1;
    acc(1'b0, `HPX_SEL_DATA_INC, 1'b1, 32'h3300);
    h_be_n <= 4'h0;
    wait_wr(2);
    chk(wb[1], 4'hb);
    chk(wa[1], 32'h8000_1238);
    chk(wd[1], 32'h3300_5566);
    chk(o_core_hold, 1'b1);
    acc(1'b0, `HPX_SEL_CTRL, 1'b0, 32'h3);
    repeat (4) @(posedge i_clk);
    chk(o_core_hold, 1'b0);
  endtask
  task automatic t_read();
    logic [31:0] x;
    x = 32'h8000_2000 ^ 32'hc3c3_0000;
    acc(1'b0, `HPX_SEL_ADDR, 1'b0, 32'h2000);
    acc(1'b1, `HPX_SEL_DATA_INC, 1'b0, 32'h0);
    chk(ra.size(), 1);
    chk(r[15:0], x[15:0]);
    repeat (20) @(posedge i_clk);
    chk(ra.size(), 1);
    acc(1'b1, `HPX_SEL_DATA_INC, 1'b1, 32'h0);
    chk(r[15:0], x[31:16]);
    repeat (20) @(posedge i_clk);
    chk(ra[1], 32'h8000_2004);
    acc(1'b0, `HPX_SEL_ADDR, 1'b0, 32'h3000);
    apb(1'b0, `HPX_REG_STATUS, 32'h0);
    chk(r[4:3], 2'b00);
    acc(1'b1, `HPX_SEL_DATA_INC, 1'b0, 32'h0);
    chk(ra[2], 32'h8000_3000);
  endtask
  task automatic t_wide();
    int i, h;
    acc(1'b0, `HPX_SEL_ADDR, 1'b0, 32'h4000);
    apb(1'b1, `HPX_REG_CFG, 32'h1);
    h = rdy_hi;
    for (i = 0; i < HALF - 1; i++) begin
      acc(1'b0, `HPX_SEL_DATA_INC, 1'b0, 32'h1100_0000 + i);
      chk(rdy_hi, h);
    end
    chk(wa.size(), 2);
    u_hpx_host_model.select(1'b1);
    wait_wr(HALF + 1);
    chk(wa[4], 32'h8000_4008);
    chk(wd[4], 32'h1100_0002);
    chk(wq[4], `HPX_QUEUE_MED);
    for (i = 0; i < HALF; i++)
      acc(1'b0, `HPX_SEL_DATA_INC, 1'b0, 32'h2200_0000 + i);
    wait_wr(2 * HALF + 1);
    chk(wa[8], 32'h8000_4018);
    chk(wd[8], 32'h2200_0003);
    u_hpx_host_model.select(1'b1);
  endtask
  initial begin
    i_rst_n = 1'b0;
    i_chip_rst_n = 1'b0;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 12'h0;
    i_pwdata = 32'h0;
    h_be_n = 4'h0;
    mismatches = 0;
    checked = 0;
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_reset();
    t_regs();
    t_write();
    t_read();
    t_wide();
    conclude();
  end
endmodule
`default_nettype wire
